// [shared/fab_pkg.sv]
// shared constants, types and parity helper for both address-phase ends
`default_nettype none
package fab_pkg;
  // ****************************************************
  // clocking and timing
  // ****************************************************
  localparam int unsigned CLK_MHZ = 40;
  // strobe half period made by the driving end
  localparam int unsigned STB_HALF_NS = 100;
  localparam int unsigned STB_HALF_CYC = (STB_HALF_NS * CLK_MHZ + 999) / 1000;
  // time the strap end keeps straps after releasing bus reset
  localparam int unsigned CFG_HOLD_NS = 200;
  localparam int unsigned CFG_HOLD_CYC = (CFG_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] HALF_CNT = 8'(STB_HALF_CYC - 1);
  localparam logic [7:0] HOLD_CNT = 8'(CFG_HOLD_CYC - 1);

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int unsigned ADDR_HI = 35;
  localparam int unsigned ADDR_LO = 3;
  localparam int unsigned STB1_LO = 17;
  localparam int unsigned STB0_HI = 16;
  localparam int unsigned PAR_SPLIT = 24;
  localparam int unsigned REQ_W = 5;
  localparam int unsigned A20_BIT = 20;
  localparam int unsigned CFG_LSB = 27;
  localparam int unsigned CFG_W = 5;

  // ****************************************************
  // types and reset values
  // ****************************************************
  typedef logic [ADDR_HI:ADDR_LO] fab_addr_t;
  typedef logic [REQ_W-1:0] fab_req_t;
  typedef logic [CFG_W-1:0] fab_cfg_t;
  localparam fab_addr_t ADDR_REL = '1;
  localparam fab_cfg_t CFG_RST = '0;

  // pin-level parity; bit 0 is the first parity line
  function automatic logic [1:0] fab_par(fab_addr_t a, fab_req_t r, logic sub2);
    logic hi;
    logic lo;
    hi = ~(^(~a[ADDR_HI:PAR_SPLIT]));
    lo = ~(^(~{a[PAR_SPLIT-1:ADDR_LO], r}));
    fab_par = sub2 ? {hi, lo} : {lo, hi};
  endfunction
endpackage
`default_nettype wire

// [shared/fab_bus_if.sv]
// pin-level address-phase bus joining the processor end and the agent end
`timescale 1ns/1ps
`default_nettype none
interface fab_bus_if;
  import fab_pkg::*;
  // ****************************************************
  // shared address lines, driven by either end
  // ****************************************************
  fab_addr_t dev_addr_o;
  fab_addr_t dev_addr_oe_n;
  fab_addr_t agt_addr_o;
  fab_addr_t agt_addr_oe_n;
  fab_addr_t addr;
  // ****************************************************
  // request, strobe, parity and start lines
  // ****************************************************
  fab_req_t dev_req_o;
  logic dev_req_oe_n;
  fab_req_t req;
  logic [1:0] dev_stb_o;
  logic dev_stb_oe_n;
  logic [1:0] address_strobes_n;
  logic [1:0] dev_par_o;
  logic dev_par_oe_n;
  logic [1:0] addr_parity_n;
  logic dev_ads_o;
  logic dev_ads_oe_n;
  logic ads_n;
  logic bus_reset_n;
  logic addr_bit20_mask_n;
  // wired-and with pull-up: a released line reads high
  assign addr = (dev_addr_o | dev_addr_oe_n) & (agt_addr_o | agt_addr_oe_n);
  assign req = dev_req_o | {REQ_W{dev_req_oe_n}};
  assign address_strobes_n = dev_stb_o | {2{dev_stb_oe_n}};
  assign addr_parity_n = dev_par_o | {2{dev_par_oe_n}};
  assign ads_n = dev_ads_o | dev_ads_oe_n;

  modport dev (
    input addr, bus_reset_n, addr_bit20_mask_n,
    output dev_addr_o, dev_addr_oe_n, dev_req_o, dev_req_oe_n, dev_stb_o,
    output dev_stb_oe_n, dev_par_o, dev_par_oe_n, dev_ads_o, dev_ads_oe_n
  );
  modport agt (
    input addr, req, address_strobes_n, addr_parity_n, ads_n,
    output agt_addr_o, agt_addr_oe_n, bus_reset_n, addr_bit20_mask_n
  );
endinterface
`default_nettype wire

// [hw/fab_agent_end.sv]
// bus agent end: captures address phases and drives reset, straps and mask
`timescale 1ns/1ps
`default_nettype none
module fab_agent_end
  import fab_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // bus pins
  fab_bus_if.agt bus,
  // system control
  input wire logic i_bus_reset,
  input wire logic i_a20_mask,
  input wire fab_cfg_t i_cfg,
  // captured address phase
  output logic o_rx_valid,
  output fab_addr_t o_rx_addr,
  output fab_addr_t o_rx_type,
  output fab_req_t o_rx_code1,
  output fab_req_t o_rx_code2,
  output logic o_par_err
);
  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    fab_addr_t [2:0] a_sy;
    fab_req_t [2:0] r_sy;
    logic [2:0][1:0] s_sy;
    logic [2:0][1:0] p_sy;
    logic [2:0] d_sy;
    logic [1:0] stb_f;
    fab_addr_t a1;
    fab_addr_t a2;
    fab_req_t r1;
    fab_req_t r2;
    logic [1:0] p1;
    logic [1:0] p2;
    logic in_ph;
    logic pend;
    logic rx_valid;
    fab_addr_t rx_addr;
    fab_addr_t rx_type;
    fab_req_t rx_c1;
    fab_req_t rx_c2;
    logic par_err;
    logic rst_o;
    logic a20_o;
    logic [7:0] hcnt;
    logic strap_on;
    fab_addr_t st_o;
    fab_addr_t st_oe_n;
  } fab_agt_s_t;

  fab_agt_s_t s_q;
  fab_agt_s_t s_d;
  logic [1:0] fall;
  logic [1:0] rise;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    s_d = s_q;
    s_d.rx_valid = 1'b0;
    // three-stage sync; a change counts once stages two and three agree
    s_d.a_sy = {s_q.a_sy[1:0], bus.addr};
    s_d.r_sy = {s_q.r_sy[1:0], bus.req};
    s_d.s_sy = {s_q.s_sy[1:0], bus.address_strobes_n};
    s_d.p_sy = {s_q.p_sy[1:0], bus.addr_parity_n};
    s_d.d_sy = {s_q.d_sy[1:0], bus.ads_n};
    for (int i = 0; i < 2; i++) begin
      if (s_q.s_sy[1][i] == s_q.s_sy[2][i]) begin
        s_d.stb_f[i] = s_q.s_sy[2][i];
      end
    end
    fall = s_q.stb_f & ~s_d.stb_f;
    rise = ~s_q.stb_f & s_d.stb_f;
    // strobe edges latch from the clock domain, not the bus clock
    if (fall[0] && !s_q.d_sy[2]) begin
      s_d.in_ph = 1'b1;
      s_d.r1 = s_q.r_sy[2];
      s_d.a1[STB0_HI:ADDR_LO] = s_q.a_sy[2][STB0_HI:ADDR_LO];
      s_d.p1 = s_q.p_sy[2];
    end
    if (fall[1] && s_d.in_ph) begin
      s_d.a1[ADDR_HI:STB1_LO] = s_q.a_sy[2][ADDR_HI:STB1_LO];
    end
    if (rise[0] && s_d.in_ph) begin
      s_d.r2 = s_q.r_sy[2];
      s_d.a2[STB0_HI:ADDR_LO] = s_q.a_sy[2][STB0_HI:ADDR_LO];
      s_d.p2 = s_q.p_sy[2];
    end
    if (rise[1] && s_d.in_ph) begin
      s_d.a2[ADDR_HI:STB1_LO] = s_q.a_sy[2][ADDR_HI:STB1_LO];
      s_d.in_ph = 1'b0;
      s_d.pend = 1'b1;
    end
    // report one cycle after the last strobe edge
    if (s_q.pend) begin
      s_d.pend = 1'b0;
      s_d.rx_valid = 1'b1;
      s_d.rx_addr = ~s_q.a1;
      s_d.rx_type = ~s_q.a2;
      s_d.rx_c1 = ~s_q.r1;
      s_d.rx_c2 = ~s_q.r2;
      s_d.par_err = (s_q.p1 != fab_par(s_q.a1, s_q.r1, 1'b0))
                  | (s_q.p2 != fab_par(s_q.a2, s_q.r2, 1'b1));
    end
    // straps stay on past reset release so the far end samples them
    s_d.rst_o = ~i_bus_reset;
    s_d.a20_o = ~i_a20_mask;
    if (i_bus_reset) begin
      s_d.strap_on = 1'b1;
      s_d.hcnt = HOLD_CNT;
    end else if (s_q.hcnt != 8'h00) begin
      s_d.hcnt = s_q.hcnt - 8'h01;
    end else begin
      s_d.strap_on = 1'b0;
    end
    s_d.st_o = ADDR_REL;
    s_d.st_oe_n = ADDR_REL;
    if (s_d.strap_on) begin
      s_d.st_o[CFG_LSB+:CFG_W] = ~i_cfg;
      s_d.st_oe_n[CFG_LSB+:CFG_W] = '0;
    end
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '{a_sy: '1, r_sy: '1, s_sy: '1, p_sy: '1, d_sy: '1, stb_f: 2'h3,
               rst_o: 1'b0, a20_o: 1'b1, st_o: '1, st_oe_n: '1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.agt_addr_o = s_q.st_o;
  assign bus.agt_addr_oe_n = s_q.st_oe_n;
  assign bus.bus_reset_n = s_q.rst_o;
  assign bus.addr_bit20_mask_n = s_q.a20_o;
  assign o_rx_valid = s_q.rx_valid;
  assign o_rx_addr = s_q.rx_addr;
  assign o_rx_type = s_q.rx_type;
  assign o_rx_code1 = s_q.rx_c1;
  assign o_rx_code2 = s_q.rx_c2;
  assign o_par_err = s_q.par_err;
endmodule // fab_agent_end
`default_nettype wire

// [hw/fab_cpu_end.sv]
// processor end: drives two-sub-phase address phases, masks bit 20, takes straps
`timescale 1ns/1ps
`default_nettype none
module fab_cpu_end
  import fab_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // bus pins
  fab_bus_if.dev bus,
  // request port
  input wire logic i_req_valid,
  input wire fab_addr_t i_req_addr,
  input wire fab_addr_t i_req_type,
  input wire fab_req_t i_req_code1,
  input wire fab_req_t i_req_code2,
  input wire logic i_real_mode,
  output logic o_req_ready,
  output logic o_done,
  // cache lookup port
  output logic o_lookup_valid,
  output fab_addr_t o_lookup_addr,
  // status
  output fab_cfg_t o_cfg,
  output logic o_cfg_valid,
  output logic o_a20_active
);
  // ****************************************************
  // state
  // ****************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_P1_SET = 3'b001,
    ST_P1_HOLD = 3'b010,
    ST_P2_SET = 3'b011,
    ST_P2_HOLD = 3'b100
  } fab_cpu_st_t;

  typedef struct packed {
    fab_cpu_st_t st;
    logic [7:0] cnt;
    logic [2:0] rst_sy;
    logic rst_f;
    logic [2:0] a20_sy;
    logic a20_f;
    fab_cfg_t [2:0] cfg_sy;
    fab_addr_t addr_o;
    fab_addr_t word2;
    fab_req_t req_o;
    fab_req_t code2;
    logic [1:0] stb_o;
    logic [1:0] par_o;
    logic ads_o;
    logic oe_n;
    logic ready;
    logic done;
    logic lk_valid;
    fab_addr_t lk_addr;
    fab_cfg_t cfg;
    logic cfg_valid;
    logic a20_act;
  } fab_cpu_s_t;

  fab_cpu_s_t s_q;
  fab_cpu_s_t s_d;
  fab_addr_t masked;
  logic a20_on;
  logic accept;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.lk_valid = 1'b0;
    // pins are asynchronous here; first stages feed only the next stage
    s_d.rst_sy = {s_q.rst_sy[1:0], bus.bus_reset_n};
    s_d.a20_sy = {s_q.a20_sy[1:0], bus.addr_bit20_mask_n};
    s_d.cfg_sy = {s_q.cfg_sy[1:0], bus.addr[CFG_LSB+:CFG_W]};
    if (s_q.rst_sy[1] == s_q.rst_sy[2]) begin
      s_d.rst_f = s_q.rst_sy[2];
    end
    if (s_q.a20_sy[1] == s_q.a20_sy[2]) begin
      s_d.a20_f = s_q.a20_sy[2];
    end

    // mask bit 20 only in real mode; elsewhere the input is ignored
    a20_on = ~s_q.a20_f & i_real_mode;
    s_d.a20_act = ~s_d.a20_f & i_real_mode;
    masked = i_req_addr;
    if (a20_on) begin
      masked[A20_BIT] = 1'b0;
    end
    accept = i_req_valid & s_q.ready;

    unique case (s_q.st)
      ST_IDLE: begin
        if (s_q.cnt != 8'h00) begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
        if (accept) begin
          // cache lookup sees the masked address on the same edge as the bus does
          s_d.lk_valid = 1'b1;
          s_d.lk_addr = masked;
          s_d.addr_o = ~masked;
          s_d.req_o = ~i_req_code1;
          s_d.word2 = ~i_req_type;
          s_d.code2 = ~i_req_code2;
          s_d.par_o = fab_par(~masked, ~i_req_code1, 1'b0);
          s_d.ads_o = 1'b0;
          s_d.oe_n = 1'b0;
          s_d.stb_o = 2'h3;
          s_d.cnt = HALF_CNT;
          s_d.st = ST_P1_SET;
        end
      end
      ST_P1_SET: begin
        s_d.cnt = s_q.cnt - 8'h01;
        if (s_q.cnt == 8'h00) begin
          // both strobes fall together: first latch edge
          s_d.stb_o = 2'h0;
          s_d.cnt = HALF_CNT;
          s_d.st = ST_P1_HOLD;
        end
      end
      ST_P1_HOLD: begin
        s_d.cnt = s_q.cnt - 8'h01;
        if (s_q.cnt == 8'h00) begin
          // data changes midway between edges, a half period clear
          s_d.addr_o = s_q.word2;
          s_d.req_o = s_q.code2;
          s_d.par_o = fab_par(s_q.word2, s_q.code2, 1'b1);
          s_d.ads_o = 1'b1;
          s_d.cnt = HALF_CNT;
          s_d.st = ST_P2_SET;
        end
      end
      ST_P2_SET: begin
        s_d.cnt = s_q.cnt - 8'h01;
        if (s_q.cnt == 8'h00) begin
          s_d.stb_o = 2'h3;
          s_d.cnt = HALF_CNT;
          s_d.st = ST_P2_HOLD;
        end
      end
      ST_P2_HOLD: begin
        s_d.cnt = s_q.cnt - 8'h01;
        if (s_q.cnt == 8'h00) begin
          s_d.addr_o = ADDR_REL;
          s_d.req_o = '1;
          s_d.par_o = 2'h3;
          s_d.oe_n = 1'b1;
          s_d.done = 1'b1;
          s_d.cnt = 8'h00;
          s_d.st = ST_IDLE;
        end
      end
    endcase

    // bus reset aborts any phase and releases every line
    if (!s_d.rst_f) begin
      s_d.st = ST_IDLE;
      s_d.addr_o = ADDR_REL;
      s_d.req_o = '1;
      s_d.par_o = 2'h3;
      s_d.stb_o = 2'h3;
      s_d.ads_o = 1'b1;
      s_d.oe_n = 1'b1;
      s_d.cfg_valid = 1'b0;
    end
    // release edge: take straps, then wait out the agent's strap hold
    if (!s_q.rst_f && s_d.rst_f) begin
      s_d.cfg = ~s_q.cfg_sy[2];
      s_d.cfg_valid = 1'b1;
      s_d.cnt = HOLD_CNT;
    end
    // a request right after release would collide with straps still driven
    s_d.ready = (s_d.st == ST_IDLE) && s_d.rst_f && (s_d.cnt == 8'h00);
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '{st: ST_IDLE, a20_sy: 3'h7, a20_f: 1'b1, addr_o: '1,
               req_o: '1, stb_o: 2'h3, par_o: 2'h3, ads_o: 1'b1, oe_n: 1'b1,
               cfg: CFG_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************
  // outputs, all straight from the state register
  // ****************************************************
  assign bus.dev_addr_o = s_q.addr_o;
  assign bus.dev_addr_oe_n = {($bits(fab_addr_t)){s_q.oe_n}};
  assign bus.dev_req_o = s_q.req_o;
  assign bus.dev_req_oe_n = s_q.oe_n;
  assign bus.dev_stb_o = s_q.stb_o;
  assign bus.dev_stb_oe_n = s_q.oe_n;
  assign bus.dev_par_o = s_q.par_o;
  assign bus.dev_par_oe_n = s_q.oe_n;
  assign bus.dev_ads_o = s_q.ads_o;
  assign bus.dev_ads_oe_n = s_q.oe_n;
  assign o_req_ready = s_q.ready;
  assign o_done = s_q.done;
  assign o_lookup_valid = s_q.lk_valid;
  assign o_lookup_addr = s_q.lk_addr;
  assign o_cfg = s_q.cfg;
  assign o_cfg_valid = s_q.cfg_valid;
  assign o_a20_active = s_q.a20_act;
endmodule // fab_cpu_end
`default_nettype wire

// [test/fab_addr_assertions.sv]
// concurrent checks on the address-phase pins joining the two ends
`timescale 1ns/1ps
`default_nettype none
module fab_addr_assertions
  import fab_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // resolved bus pins
  input wire fab_addr_t addr,
  input wire fab_req_t req,
  input wire logic [1:0] address_strobes_n,
  input wire logic [1:0] addr_parity_n,
  input wire logic ads_n,
  input wire logic bus_reset_n,
  // drive enables of both ends
  input wire fab_addr_t dev_addr_oe_n,
  input wire logic dev_par_oe_n,
  input wire fab_addr_t agt_addr_oe_n
);
  logic par_hi;
  logic par_lo;
  // expected parity pins, worked from pin levels so polarity slips show up
  assign par_hi = ~^(~addr[35:24]);
  assign par_lo = ~^(~{addr[23:3], req});
  default clocking cb_main @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ****************************************************
  // address phase framing
  // ****************************************************
  property p_par_sub1; (!ads_n && !dev_par_oe_n) |-> addr_parity_n == {par_lo, par_hi};
  endproperty
  a_par_sub1: assert property (p_par_sub1)
    else $error("parity pins wrong in first sub-phase");
  property p_par_sub2; (ads_n && !dev_par_oe_n) |-> addr_parity_n == {par_hi, par_lo};
  endproperty
  a_par_sub2: assert property (p_par_sub2)
    else $error("parity pins wrong in second sub-phase");
  property p_ads_width; $fell(ads_n) |-> (!ads_n)[*8] ##1 ads_n; endproperty
  a_ads_width: assert property (p_ads_width)
    else $error("start line low for wrong length");
  property p_stb_fall; $fell(ads_n) |-> address_strobes_n == 2'b11 ##4 address_strobes_n == 2'b00;
  endproperty
  a_stb_fall: assert property (p_stb_fall)
    else $error("strobes did not fall four cycles into the phase");
  property p_stb_rise;
    $fell(address_strobes_n[0]) |-> (address_strobes_n == 2'b00)[*8] ##0 ads_n
      ##1 (address_strobes_n == 2'b11);
  endproperty
  a_stb_rise: assert property (p_stb_rise)
    else $error("strobes did not rise after the second sub-phase");
  property p_release;
    $rose(address_strobes_n[0]) |-> ##3 (dev_addr_oe_n != '1) ##1 (dev_addr_oe_n == '1 && ads_n);
  endproperty
  a_release: assert property (p_release)
    else $error("address lines not released four cycles after strobe rise");
  property p_stable; $changed(address_strobes_n) |-> $stable(addr) && $stable(req); endproperty
  a_stable: assert property (p_stable)
    else $error("address lines moved at a strobe edge");
  // ****************************************************
  // strap window
  // ****************************************************
  property p_no_clash; (dev_addr_oe_n != '1) |-> (agt_addr_oe_n == '1); endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the address lines");
  property p_cfg_hold;
    $rose(bus_reset_n) |-> (agt_addr_oe_n != '1)[*5] ##[1:5] (agt_addr_oe_n == '1);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("straps not held then released after bus reset");
endmodule // fab_addr_assertions
`default_nettype wire

// [test/fsb_address_phase_and_a20_mask_test.sv]
// self-checking bench joining the processor end and the agent end
`timescale 1ns/1ps
`default_nettype none
module fsb_address_phase_and_a20_mask_test;
  import fab_pkg::*;
  typedef struct packed {fab_addr_t a; fab_addr_t t; fab_req_t c1; fab_req_t c2;} fab_exp_t;
  logic i_clk, i_resetn, i_req_valid, i_real_mode, i_bus_reset, i_a20_mask, exp_mask;
  logic o_req_ready, o_done, o_lookup_valid, o_cfg_valid, o_a20_active, o_rx_valid, o_par_err;
  fab_addr_t i_req_addr, i_req_type, o_lookup_addr, o_rx_addr, o_rx_type;
  fab_req_t i_req_code1, i_req_code2, o_rx_code1, o_rx_code2;
  fab_cfg_t i_cfg, o_cfg;
  int fails, compares, cyc, t0, seed;
  fab_exp_t q_lk[$], q_rx[$], e;
  fab_bus_if bus();
  fab_cpu_end u_fab_cpu_end (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus),
    .i_req_valid(i_req_valid), .i_req_addr(i_req_addr), .i_req_type(i_req_type),
    .i_req_code1(i_req_code1), .i_req_code2(i_req_code2), .i_real_mode(i_real_mode),
    .o_req_ready(o_req_ready), .o_done(o_done), .o_lookup_valid(o_lookup_valid),
    .o_lookup_addr(o_lookup_addr), .o_cfg(o_cfg), .o_cfg_valid(o_cfg_valid),
    .o_a20_active(o_a20_active));
  fab_agent_end u_fab_agent_end (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus),
    .i_bus_reset(i_bus_reset), .i_a20_mask(i_a20_mask), .i_cfg(i_cfg), .o_rx_valid(o_rx_valid),
    .o_rx_addr(o_rx_addr), .o_rx_type(o_rx_type), .o_rx_code1(o_rx_code1),
    .o_rx_code2(o_rx_code2), .o_par_err(o_par_err));
  fab_addr_assertions u_fab_addr_assertions (.i_clk(i_clk), .i_resetn(i_resetn),
    .addr(bus.addr), .req(bus.req), .address_strobes_n(bus.address_strobes_n),
    .addr_parity_n(bus.addr_parity_n), .ads_n(bus.ads_n), .bus_reset_n(bus.bus_reset_n),
    .dev_addr_oe_n(bus.dev_addr_oe_n), .dev_par_oe_n(bus.dev_par_oe_n),
    .agt_addr_oe_n(bus.agt_addr_oe_n));
  // 40 MHz bench clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // ****************************************************
  // compare and report
  // ****************************************************
  task automatic note(input bit bad, input logic [35:0] g, input logic [35:0] x);
    compares++;
    if (bad) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic cmp_a(input fab_addr_t g, x); note(g !== x, 36'(g), 36'(x)); endtask
  task automatic cmp_c(input logic [4:0] g, x); note(g !== x, 36'(g), 36'(x)); endtask
  task automatic cmp_b(input logic g, x); note(g !== x, 36'(g), 36'(x)); endtask
  task automatic cmp_n(input int g, x); note(g != x, 36'(g), 36'(x)); endtask
  task automatic end_test(input string s); $display("test %s done", s); endtask
  task automatic final_report();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // model check at every result; pre-edge values are what the design launched
  always @(posedge i_clk) begin
    if (o_lookup_valid === 1'b1) begin
      e = q_lk[0];
      cmp_n(cyc - t0, 1);
      cmp_a(o_lookup_addr, e.a);
    end
    if (o_done === 1'b1) begin
      cmp_n(cyc - t0, 17);
      void'(q_lk.pop_front());
    end
    // noted after the done check: a back-to-back take lands on the done edge
    if (i_resetn && i_req_valid === 1'b1 && o_req_ready === 1'b1) t0 = cyc;
    if (o_rx_valid === 1'b1) begin
      e = q_rx.pop_front();
      cmp_a(o_rx_addr, e.a);
      cmp_a(o_rx_type, e.t);
      cmp_c(o_rx_code1, e.c1);
      cmp_c(o_rx_code2, e.c2);
      cmp_b(o_par_err, 1'b0);
    end
    cyc++;
    // a hang counts as a mismatch
    if (cyc == 4000) begin
      fails++;
      final_report();
    end
  end
  // ****************************************************
  // stimulus
  // ****************************************************
  // hold a request until taken; later requests wait out the busy window
  task automatic send(input fab_addr_t a, input fab_addr_t t);
    fab_exp_t x;
    int n;
    x = {a, t, fab_req_t'($random(seed)), fab_req_t'($random(seed))};
    i_req_valid = 1'b1;
    i_req_addr = a;
    i_req_type = t;
    i_req_code1 = x.c1;
    i_req_code2 = x.c2;
    x.a[A20_BIT] = a[A20_BIT] & ~exp_mask;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_req_ready !== 1'b1 && n < 100);
    q_lk.push_back(x);
    q_rx.push_back(x);
    @(negedge i_clk);
  endtask
  task automatic batch(input int k, input bit one20);
    fab_addr_t a;
    for (int i = 0; i < k; i++) begin
      a = fab_addr_t'({$random(seed), $random(seed)});
      a[A20_BIT] = a[A20_BIT] | one20;
      send(a, fab_addr_t'({$random(seed), $random(seed)}));
    end
    i_req_valid = 1'b0;
    repeat (30) @(negedge i_clk);
  endtask
  // mask pin passes a filter, so settle before the next request
  task automatic set_mode(input logic m, input logic r);
    i_a20_mask = m;
    i_real_mode = r;
    exp_mask = m & r;
    repeat (12) @(negedge i_clk);
    cmp_b(o_a20_active, exp_mask);
  endtask
  task automatic bus_rst(input fab_cfg_t c);
    int n;
    i_bus_reset = 1'b1;
    i_cfg = c;
    repeat (10) @(negedge i_clk);
    i_bus_reset = 1'b0;
    n = 0;
    while (o_req_ready !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    cmp_b(o_cfg_valid, 1'b1);
    cmp_c(o_cfg, c);
  endtask
  initial begin
    seed = 32'hfdc0;
    {i_resetn, i_req_valid, i_a20_mask, exp_mask, fails, compares, cyc, t0} = '0;
    {i_req_addr, i_req_type, i_req_code1, i_req_code2, i_cfg} = '0;
    i_real_mode = 1'b1;
    i_bus_reset = 1'b1;
    repeat (10) @(negedge i_clk);
    i_resetn = 1'b1;
    bus_rst(fab_cfg_t'($random(seed)));
    end_test("straps");
    send('1, '0);
    send('0, '1);
    batch(4, 1'b0);
    end_test("phases");
    set_mode(1'b1, 1'b1);
    batch(3, 1'b1);
    end_test("mask");
    set_mode(1'b1, 1'b0);
    batch(3, 1'b1);
    set_mode(1'b0, 1'b1);
    batch(2, 1'b1);
    end_test("modes");
    bus_rst(fab_cfg_t'($random(seed)));
    batch(2, 1'b0);
    cmp_n(q_rx.size(), 0);
    cmp_n(q_lk.size(), 0);
    end_test("restrap");
    final_report();
  end
endmodule // fsb_address_phase_and_a20_mask_test
`default_nettype wire
